// >>> rtl/mcpl_defs.vh
`ifndef MCPL_DEFS_VH
`define MCPL_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MCPL_OFF_CTRL     12'h000
`define MCPL_OFF_STATUS   12'h004
`define MCPL_OFF_IRQ_STAT 12'h008
`define MCPL_OFF_IRQ_MASK 12'h00C
`define MCPL_OFF_ID       12'h010

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define MCPL_CTRL_FAULT    0
`define MCPL_CTRL_CRIT     1
`define MCPL_CTRL_PRESENT  2
`define MCPL_CTRL_INITDONE 3
`define MCPL_CTRL_RST      32'h0000_0004

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define MCPL_ST_SELECTED  0
`define MCPL_ST_LOWPWR    1
`define MCPL_ST_NOTREADY  2
`define MCPL_ST_INRESET   3

// ----------------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------------
`define MCPL_IRQ_RSTDONE  0
`define MCPL_IRQ_FAULT    1
`define MCPL_IRQ_CRIT     2
`define MCPL_IRQ_WIDTH    3
`define MCPL_IRQ_MASK_RST 3'h7

// ----------------------------------------------------------------------------
// Timing and identity
// ----------------------------------------------------------------------------
`define MCPL_RST_MIN_CYC  16'h0014
`define MCPL_CNT_WIDTH    16
// Identity value is arbitrary.
`define MCPL_ID_VALUE     32'h00C0_FFEE

`endif

// >>> rtl/mcpl_top.v
// Functional notes
// - serial bus answered only while select low
// - long reset low restores control and interrupt mask defaults
// - reset done raises alert, notready cleared
// - power-up posts reset-done alert itself
// - low-power input caps power consumption
// - presence line pulled low when inserted
// - alert low flags fault or critical status
// - alert only pulls low, open drain
// - seven low-speed control signals provided
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "mcpl_defs.vh"

module mcpl_top #(
  parameter [15:0] RST_MIN_CYC = `MCPL_RST_MIN_CYC
) (
  // System
  input  wire        sys_clk,
  input  wire        srst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Host control pins
  input  wire        module_select_n,
  input  wire        module_reset_n,
  input  wire        power_limit_input,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  output reg         presence_detect_n,
  output reg         presence_oe,
  output reg         alert_out,
  output reg         alert_oe,
  // Internal serial engine side
  output reg         serial_enable,
  output reg         serial_scl,
  output reg         serial_sda,
  input  wire        serial_sda_drive_low,
  output reg         power_cap,
  // Interrupt
  output reg         irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  // Boot lasts one cycle, so that power-up posts the same reset-done event as a pin reset.
  localparam ST_BOOT = 2'h0;
  localparam ST_RUN  = 2'h1;
  localparam ST_RST  = 2'h2;

  reg [1:0]                  state_ff;
  reg [1:0]                  nxt_state;
  reg [`MCPL_CNT_WIDTH-1:0]  low_cnt_ff;
  reg [`MCPL_CNT_WIDTH-1:0]  nxt_low_cnt;
  reg [31:0]                 ctrl_ff;
  reg [31:0]                 nxt_ctrl;
  reg                        notready_ff;
  reg                        nxt_notready;
  reg [`MCPL_IRQ_WIDTH-1:0]  irq_stat_ff;
  wire [`MCPL_IRQ_WIDTH-1:0] nxt_irq_stat;
  reg [`MCPL_IRQ_WIDTH-1:0]  irq_mask_ff;
  reg [`MCPL_IRQ_WIDTH-1:0]  nxt_irq_mask;
  reg                        fault_d_ff;
  reg                        crit_d_ff;
  reg [31:0]                 nxt_prdata;
  reg                        nxt_pslverr;
  reg [31:0]                 status_word;
  wire [`MCPL_IRQ_WIDTH-1:0] irq_live;

  wire apb_acc   = psel & penable & ~pready;
  wire apb_wr    = apb_acc & pwrite;
  wire long_low  = (low_cnt_ff >= RST_MIN_CYC);
  wire rst_done  = (state_ff == ST_BOOT) | ((state_ff == ST_RST) & module_reset_n);
  wire [`MCPL_IRQ_WIDTH-1:0] ev;
  wire [`MCPL_IRQ_WIDTH-1:0] w1c;

  // --------------------------------------------------------------------------
  // Events
  // --------------------------------------------------------------------------
  assign ev[`MCPL_IRQ_RSTDONE] = rst_done;
  assign ev[`MCPL_IRQ_FAULT]   = ctrl_ff[`MCPL_CTRL_FAULT] & ~fault_d_ff;
  assign ev[`MCPL_IRQ_CRIT]    = ctrl_ff[`MCPL_CTRL_CRIT] & ~crit_d_ff;
  assign w1c = (apb_wr && paddr == `MCPL_OFF_IRQ_STAT) ? pwdata[`MCPL_IRQ_WIDTH-1:0] : {`MCPL_IRQ_WIDTH{1'b0}};

  // --------------------------------------------------------------------------
  // Interrupt status, one sticky flag per event
  // --------------------------------------------------------------------------
  // Set wins over a simultaneous write-one-to-clear, so an event that lands in
  // the same cycle as the software clear is never lost.
  genvar gi;
  generate
    for (gi = 0; gi < `MCPL_IRQ_WIDTH; gi = gi + 1) begin : g_irq_bit
      assign nxt_irq_stat[gi] = (irq_stat_ff[gi] & ~w1c[gi]) | ev[gi];
      // The mask is taken at its next value, so the pin never lags a mask write.
      assign irq_live[gi]     = nxt_irq_stat[gi] & nxt_irq_mask[gi];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Reset pulse filter and sequencing
  // --------------------------------------------------------------------------
  // The count saturates at the minimum, so a pin held low for a long time
  // cannot wrap it back to zero and end the reset by itself.
  always @* begin
    nxt_low_cnt = low_cnt_ff;
    if (module_reset_n) begin
      nxt_low_cnt = {`MCPL_CNT_WIDTH{1'b0}};
    end else if (!long_low) begin
      nxt_low_cnt = low_cnt_ff + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // Module reset sequencing
  // --------------------------------------------------------------------------
  always @* begin
    nxt_state    = state_ff;
    nxt_notready = notready_ff;
    case (state_ff)
      ST_BOOT: begin
        nxt_state    = ST_RUN;
        nxt_notready = 1'b0;
      end
      ST_RUN: begin
        // Short glitches never reach here: the count must reach the minimum.
        if (long_low) begin
          nxt_state    = ST_RST;
          nxt_notready = 1'b1;
        end
      end
      ST_RST: begin
        // Only the release of the pin ends the reset, however long it was held.
        if (module_reset_n) begin
          nxt_state    = ST_RUN;
          nxt_notready = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_BOOT;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  // Pin levels are shown live; software must not trust the word while the
  // in-reset bit is set.
  always @* begin
    status_word                    = 32'h0000_0000;
    status_word[`MCPL_ST_SELECTED] = ~module_select_n;
    status_word[`MCPL_ST_LOWPWR]   = power_limit_input;
    status_word[`MCPL_ST_NOTREADY] = notready_ff;
    status_word[`MCPL_ST_INRESET]  = (state_ff == ST_RST);
  end

  // --------------------------------------------------------------------------
  // Registers and APB decode
  // --------------------------------------------------------------------------
  // Unmapped offsets answer with an error and change nothing.
  always @* begin
    nxt_ctrl     = ctrl_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_prdata   = 32'h0000_0000;
    nxt_pslverr  = 1'b0;
    if (apb_acc) begin
      case (paddr)
        `MCPL_OFF_CTRL: begin
          if (pwrite) begin
            nxt_ctrl = {28'h0000000, pwdata[3:0]};
          end
          nxt_prdata = ctrl_ff;
        end
        `MCPL_OFF_STATUS: begin
          nxt_prdata = status_word;
        end
        `MCPL_OFF_IRQ_STAT: begin
          nxt_prdata = {29'h00000000, irq_stat_ff};
        end
        `MCPL_OFF_IRQ_MASK: begin
          if (pwrite) begin
            nxt_irq_mask = pwdata[`MCPL_IRQ_WIDTH-1:0];
          end
          nxt_prdata = {29'h00000000, irq_mask_ff};
        end
        `MCPL_OFF_ID: begin
          nxt_prdata = `MCPL_ID_VALUE;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    // Defaults land once, on entry to reset; writes made while the pin is
    // still held low are kept.
    if (state_ff == ST_RUN && long_low) begin
      nxt_ctrl     = `MCPL_CTRL_RST;
      nxt_irq_mask = `MCPL_IRQ_MASK_RST;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencing flip-flops
  // --------------------------------------------------------------------------
  // Not-ready comes up set, so software never sees ready before the boot event.
  always @(posedge sys_clk) begin
    if (srst) begin
      state_ff    <= ST_BOOT;
      low_cnt_ff  <= {`MCPL_CNT_WIDTH{1'b0}};
      notready_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      low_cnt_ff  <= nxt_low_cnt;
      notready_ff <= nxt_notready;
    end
  end

  // --------------------------------------------------------------------------
  // Register flip-flops
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      ctrl_ff     <= `MCPL_CTRL_RST;
      irq_stat_ff <= {`MCPL_IRQ_WIDTH{1'b0}};
      irq_mask_ff <= `MCPL_IRQ_MASK_RST;
      fault_d_ff  <= 1'b0;
      crit_d_ff   <= 1'b0;
    end else begin
      ctrl_ff     <= nxt_ctrl;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      fault_d_ff  <= ctrl_ff[`MCPL_CTRL_FAULT];
      crit_d_ff   <= ctrl_ff[`MCPL_CTRL_CRIT];
    end
  end

  // --------------------------------------------------------------------------
  // APB response flip-flops
  // --------------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= nxt_prdata;
      // One wait state: the answer follows the first access cycle.
      pready  <= apb_acc;
      pslverr <= nxt_pslverr;
    end
  end

  // --------------------------------------------------------------------------
  // Pin flip-flops
  // --------------------------------------------------------------------------
  // The module only ever pulls its open-drain lines low; the host pull-ups give the high level.
  always @(posedge sys_clk) begin
    if (srst) begin
      scl_out           <= 1'b0;
      scl_oe            <= 1'b0;
      sda_out           <= 1'b0;
      sda_oe            <= 1'b0;
      presence_detect_n <= 1'b0;
      presence_oe       <= 1'b0;
      alert_out         <= 1'b0;
      alert_oe          <= 1'b0;
      serial_enable     <= 1'b0;
      serial_scl        <= 1'b1;
      serial_sda        <= 1'b1;
      power_cap         <= 1'b1;
      irq               <= 1'b0;
    end else begin
      // Clock line is only ever sampled; the module never stretches it.
      scl_out           <= 1'b0;
      scl_oe            <= 1'b0;
      // Select gates the serial lines one cycle late; the serial engine must allow for it.
      serial_enable     <= ~module_select_n;
      serial_scl        <= module_select_n | scl_in;
      serial_sda        <= module_select_n | sda_in;
      sda_out           <= 1'b0;
      sda_oe            <= ~module_select_n & serial_sda_drive_low;
      presence_detect_n <= 1'b0;
      presence_oe       <= 1'b1;
      alert_out         <= 1'b0;
      alert_oe          <= |irq_live;
      power_cap         <= power_limit_input;
      irq               <= |irq_live;
    end
  end

endmodule

// >>> verif/mcpl_props.sv
`timescale 1ns/1ps
module mcpl_props #(
  parameter [15:0] RST_MIN_CYC = 16'h0014
) (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire module_select_n,
  input wire module_reset_n,
  input wire power_limit_input,
  input wire serial_enable,
  input wire sda_oe,
  input wire serial_sda_drive_low,
  input wire alert_out,
  input wire alert_oe,
  input wire power_cap,
  input wire irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Counts sampled low cycles of the reset pin, so pulse length is judged here.
  reg [15:0] low_ff;
  always @(posedge sys_clk) begin
    low_ff <= (srst | module_reset_n) ? 16'h0000 : low_ff + 16'h0001;
  end
  sequence long_low;
    !module_reset_n && (low_ff >= RST_MIN_CYC) ##1 module_reset_n;
  endsequence
  sequence short_low;
    !alert_oe && $fell(module_reset_n) ##1 !module_reset_n ##1 module_reset_n;
  endsequence
  chk_sel_idle: assert property (module_select_n [*3] |-> !serial_enable && !sda_oe)
    else $error("bus active while deselected");
  chk_sda_cause: assert property ($rose(sda_oe) |-> $past(serial_sda_drive_low && !module_select_n))
    else $error("data pulled without cause");
  chk_cap_follow: assert property (!$past(srst) |-> power_cap == $past(power_limit_input))
    else $error("power cap does not follow input");
  chk_open_drain: assert property (!alert_out)
    else $error("alert driven high");
  chk_alert_irq: assert property (alert_oe == irq)
    else $error("alert and irq differ");
  chk_boot_alert: assert property ($fell(srst) |-> ##[1:2] alert_oe)
    else $error("no alert after power-up");
  chk_rst_done: assert property (long_low |-> ##[1:3] alert_oe)
    else $error("no alert after module reset");
  chk_short_ignore: assert property (short_low |-> !alert_oe [*4])
    else $error("short reset pulse acted on");
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule
bind mcpl_top mcpl_props #(.RST_MIN_CYC(RST_MIN_CYC)) u_props (.sys_clk, .srst, .psel, .penable, .pready,
  .module_select_n, .module_reset_n, .power_limit_input, .serial_enable, .sda_oe, .serial_sda_drive_low,
  .alert_out, .alert_oe, .power_cap, .irq);

// >>> verif/mcpl_host_board.sv
`timescale 1ns/1ps
// Host board wiring: pull-ups on the alert, data and presence lines, so a released line reads high; the clock line follows host_scl.
module mcpl_host_board (
  input  wire alert_oe,
  input  wire sda_oe,
  input  wire presence_oe,
  input  wire host_scl,
  input  wire host_sda_low,
  output wire alert_n_line,
  output wire sda_line,
  output wire scl_line,
  output wire presence_line
);
  assign alert_n_line  = alert_oe ? 1'b0 : 1'b1;
  assign presence_line = presence_oe ? 1'b0 : 1'b1;
  assign sda_line      = (sda_oe | host_sda_low) ? 1'b0 : 1'b1;
  assign scl_line      = host_scl;
endmodule

// >>> verif/mcpl_tb_top.sv
`timescale 1ns/1ps
`include "mcpl_defs.vh"
module mcpl_tb_top;
  localparam [11:0] A_CT = `MCPL_OFF_CTRL, A_ST = `MCPL_OFF_STATUS;
  localparam [11:0] A_IS = `MCPL_OFF_IRQ_STAT, A_IM = `MCPL_OFF_IRQ_MASK;
  reg sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg module_select_n = 1, module_reset_n = 1, power_limit_input = 0;
  reg host_scl = 1, host_sda_low = 0, serial_sda_drive_low = 0, er;
  wire [31:0] prdata;
  wire pready, pslverr, scl_oe, sda_oe, presence_oe, alert_oe, serial_enable, serial_scl, serial_sda;
  wire power_cap, irq, alert_n_line, sda_line, scl_line, presence_line;
  wire scl_out, sda_out, presence_detect_n, alert_out;
  integer num_errors = 0, checks_done = 0;
  mcpl_top #(.RST_MIN_CYC(16'h0003)) i_dut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .module_select_n, .module_reset_n, .power_limit_input, .scl_in(scl_line),
    .scl_out, .scl_oe, .sda_in(sda_line), .sda_out, .sda_oe, .presence_detect_n, .presence_oe,
    .alert_out, .alert_oe, .serial_enable, .serial_scl, .serial_sda, .serial_sda_drive_low, .power_cap, .irq);
  mcpl_host_board i_host (.alert_oe, .sda_oe, .presence_oe, .host_scl, .host_sda_low, .alert_n_line,
    .sda_line, .scl_line, .presence_line);
  task summarize;
    begin
      if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Request is held until pready is seen high, then released at that same edge.
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin n = n + 1; @(posedge sys_clk); end
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
      if (n == 20) begin num_errors = num_errors + 1; summarize; end
    end
  endtask
  task rchk(input [11:0] a, input [31:0] exp);
    begin apb(0, a, 0); chk(rd, exp); end
  endtask
  initial forever #25 sys_clk = ~sys_clk;
  initial begin
    cyc(50000);
    num_errors = num_errors + 1;
    summarize;
  end
  initial begin
    cyc(5); srst <= 0; cyc(3);
    chk(alert_n_line, 0); chk(presence_line, 0);
    chk({scl_oe, scl_out, sda_out, presence_detect_n, alert_out}, 0);
    rchk(A_IS, 1); rchk(A_ST, 0); rchk(`MCPL_OFF_ID, `MCPL_ID_VALUE);
    apb(1, A_IS, 1); cyc(2); chk(irq, 0); chk(alert_n_line, 1);
    apb(0, 12'h020, 0); chk(er, 1); chk(rd, 0);
    apb(1, A_IM, 0); apb(1, A_CT, 5); cyc(2); chk(irq, 0); rchk(A_IS, 2);
    apb(1, A_IM, 7); cyc(2); chk(alert_n_line, 0);
    apb(1, A_CT, 6); rchk(A_IS, 6); apb(1, A_IS, 7); cyc(2); chk(irq, 0);
    serial_sda_drive_low <= 1; host_scl <= 0; cyc(4);
    chk(serial_enable, 0); chk(sda_line, 1); chk(serial_scl, 1); chk(serial_sda, 1);
    module_select_n <= 0; cyc(4);
    chk(serial_enable, 1); chk(sda_line, 0); chk(serial_scl, 0); chk(serial_sda, 0); rchk(A_ST, 1);
    module_select_n <= 1; serial_sda_drive_low <= 0; host_scl <= 1;
    power_limit_input <= 1; cyc(2); chk(power_cap, 1); rchk(A_ST, 2);
    power_limit_input <= 0;
    apb(1, A_CT, 0); cyc(2); chk(presence_line, 0); chk(power_cap, 0);
    module_reset_n <= 0; cyc(2); module_reset_n <= 1; cyc(4);
    chk(irq, 0); rchk(A_CT, 0);
    // Status is left unread while the module reset runs.
    module_reset_n <= 0; cyc(8); module_reset_n <= 1; cyc(4);
    chk(alert_n_line, 0); chk(presence_line, 0); rchk(A_CT, 4);
    rchk(A_IS, 1); rchk(A_IM, 7); rchk(A_ST, 0);
    summarize;
  end
endmodule
